// ---- src/mtcc_top.sv ----
// Machine-control transport command codec: receive decoder and key-driven sender
// Overview of operation
// - Every message opens with the exclusive start byte and real-time universal id.
// - Third byte is the destination: 00-7E one unit, 7F all units.
// - Then sub-id 06, one command byte, and the end-of-exclusive byte.
// - Received commands act only in slave mode with own or all-call destination.
// - Stop key sends a stop command to all units.
// - Accepted stop halts the transport.
// - Accepted play or deferred play starts playback unless recording; while recording it has no effect.
// - Play key sends deferred play to all units; plain play is never sent.
// - Fast forward key or shuttle right sends fast forward to all units.
// - Accepted fast forward starts fast-forward motion.
// - Rewind key or shuttle left sends rewind to all units.
// - Accepted rewind starts rewind motion.
// - Accepted record strobe while stopped begins recording.
// - Accepted record strobe while playing punches in.
// - Accepted record exit while recording punches out; otherwise no effect.
// - Finished song load sends a reset command to all units.
// - Accepted reset returns machine-control settings to power-on values.
`timescale 1ns/100ps
module mtcc_top (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               resetn_i,
    // Configuration
    input  wire logic               slave_en_i,
    input  wire logic [6:0]         own_id_i,
    // Local events
    input  mtcc_pkg::mtcc_keys_t    keys_i,
    // Received byte stream
    input  mtcc_pkg::mtcc_byte_t    rx_i,
    // Sent byte stream
    output mtcc_pkg::mtcc_byte_t    tx_o,
    input  wire logic               tx_ready_i,
    // Transport
    output mtcc_pkg::mtcc_xport_t   xport_o,
    output logic                    rec_start_o,
    output logic                    punch_in_o,
    output logic                    punch_out_o,
    output logic                    mmc_reset_o,
    // Accepted command report
    output logic                    cmd_accept_o,
    output logic [7:0]              cmd_code_o
);

    mtcc_pkg::mtcc_top_st_t q;
    mtcc_pkg::mtcc_top_st_t d;
    logic                   ser_busy;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic is_known(input logic [7:0] c);
        logic k;
        k = 1'b0;
        unique case (c)
            mtcc_pkg::CMD_STOP, mtcc_pkg::CMD_PLAY, mtcc_pkg::CMD_DPLAY,
            mtcc_pkg::CMD_FFWD, mtcc_pkg::CMD_REWD, mtcc_pkg::CMD_RSTROBE,
            mtcc_pkg::CMD_REXIT, mtcc_pkg::CMD_RESET: k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction : is_known

    function automatic logic dest_hit(input logic [6:0] dest, input logic [6:0] own);
        return (dest == own) || (dest == mtcc_pkg::ALL_CALL);
    endfunction : dest_hit

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        d           = q;
        d.accept    = 1'b0;
        d.rec_start = 1'b0;
        d.punch_in  = 1'b0;
        d.punch_out = 1'b0;
        d.mmc_reset = 1'b0;
        d.start     = 1'b0;

        // Receive decoder; real-time bytes may fall inside a message and are skipped
        if (rx_i.valid && rx_i.data < mtcc_pkg::RT_FIRST)
        begin
            if (rx_i.data == mtcc_pkg::SYSEX_START)
            begin
                d.rx_st   = mtcc_pkg::RX_UNIV;
                d.dest_ok = 1'b0;
            end
            else if (rx_i.data[7])
            begin
                d.rx_st = mtcc_pkg::RX_IDLE;
                if (q.rx_st == mtcc_pkg::RX_EOX && rx_i.data == mtcc_pkg::EOX
                    && q.dest_ok && slave_en_i)
                begin
                    d.accept  = 1'b1;
                    d.acc_cmd = q.cmd;
                    unique case (q.cmd)
                        mtcc_pkg::CMD_STOP:
                            d.xport = mtcc_pkg::XP_STOP;
                        mtcc_pkg::CMD_PLAY, mtcc_pkg::CMD_DPLAY:
                        begin
                            if (q.xport != mtcc_pkg::XP_REC)
                                d.xport = mtcc_pkg::XP_PLAY;
                        end
                        mtcc_pkg::CMD_FFWD:
                            d.xport = mtcc_pkg::XP_FFWD;
                        mtcc_pkg::CMD_REWD:
                            d.xport = mtcc_pkg::XP_REWD;
                        mtcc_pkg::CMD_RSTROBE:
                        begin
                            if (q.xport == mtcc_pkg::XP_STOP)
                            begin
                                d.xport     = mtcc_pkg::XP_REC;
                                d.rec_start = 1'b1;
                            end
                            else if (q.xport == mtcc_pkg::XP_PLAY)
                            begin
                                d.xport    = mtcc_pkg::XP_REC;
                                d.punch_in = 1'b1;
                            end
                        end
                        mtcc_pkg::CMD_REXIT:
                        begin
                            if (q.xport == mtcc_pkg::XP_REC)
                            begin
                                d.xport     = mtcc_pkg::XP_PLAY;
                                d.punch_out = 1'b1;
                            end
                        end
                        mtcc_pkg::CMD_RESET:
                        begin
                            d.xport     = mtcc_pkg::XP_STOP;
                            d.mmc_reset = 1'b1;
                        end
                        default:
                            d.accept = 1'b0;
                    endcase
                end
            end
            else
            begin
                unique case (q.rx_st)
                    mtcc_pkg::RX_UNIV:
                        d.rx_st = (rx_i.data == mtcc_pkg::UNIV_RT)
                                ? mtcc_pkg::RX_DEST : mtcc_pkg::RX_SKIP;
                    mtcc_pkg::RX_DEST:
                    begin
                        d.dest_ok = dest_hit(rx_i.data[6:0], own_id_i);
                        d.rx_st   = mtcc_pkg::RX_SUBID;
                    end
                    mtcc_pkg::RX_SUBID:
                        d.rx_st = (rx_i.data == mtcc_pkg::SUB_ID)
                                ? mtcc_pkg::RX_CMD : mtcc_pkg::RX_SKIP;
                    mtcc_pkg::RX_CMD:
                    begin
                        if (is_known(rx_i.data))
                        begin
                            d.cmd   = rx_i.data;
                            d.rx_st = mtcc_pkg::RX_EOX;
                        end
                        else
                            d.rx_st = mtcc_pkg::RX_SKIP;
                    end
                    mtcc_pkg::RX_EOX:
                        d.rx_st = mtcc_pkg::RX_SKIP;
                    mtcc_pkg::RX_IDLE, mtcc_pkg::RX_SKIP:
                        d.rx_st = q.rx_st;
                    default:
                        d.rx_st = mtcc_pkg::RX_IDLE;
                endcase
            end
        end

        // Sender: take one queued message when the serialiser is free
        if (!ser_busy && !q.start)
        begin
            if (q.pend.stop)
            begin
                d.pend.stop  = 1'b0;
                d.start      = 1'b1;
                d.start_cmd  = mtcc_pkg::CMD_STOP;
            end
            else if (q.pend.reset)
            begin
                d.pend.reset = 1'b0;
                d.start      = 1'b1;
                d.start_cmd  = mtcc_pkg::CMD_RESET;
            end
            else if (q.pend.dplay)
            begin
                d.pend.dplay = 1'b0;
                d.start      = 1'b1;
                d.start_cmd  = mtcc_pkg::CMD_DPLAY;
            end
            else if (q.pend.ffwd)
            begin
                d.pend.ffwd  = 1'b0;
                d.start      = 1'b1;
                d.start_cmd  = mtcc_pkg::CMD_FFWD;
            end
            else if (q.pend.rewd)
            begin
                d.pend.rewd  = 1'b0;
                d.start      = 1'b1;
                d.start_cmd  = mtcc_pkg::CMD_REWD;
            end
        end

        // New events queue after the take, so a same-cycle event is kept
        if (keys_i.stop)
            d.pend.stop = 1'b1;
        if (keys_i.play)
            d.pend.dplay = 1'b1;
        if (keys_i.ffwd || keys_i.shut_fwd)
            d.pend.ffwd = 1'b1;
        if (keys_i.rewd || keys_i.shut_rev)
            d.pend.rewd = 1'b1;
        if (keys_i.song_done)
            d.pend.reset = 1'b1;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            q <= '0;
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serialiser
    mtcc_tx_ser u_ser (
        .clock_i    (clock_i),
        .resetn_i   (resetn_i),
        .start_i    (q.start),
        .cmd_i      (q.start_cmd),
        .busy_o     (ser_busy),
        .tx_o       (tx_o),
        .tx_ready_i (tx_ready_i)
    );

    assign xport_o      = q.xport;
    assign rec_start_o  = q.rec_start;
    assign punch_in_o   = q.punch_in;
    assign punch_out_o  = q.punch_out;
    assign mmc_reset_o  = q.mmc_reset;
    assign cmd_accept_o = q.accept;
    assign cmd_code_o   = q.acc_cmd;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    slave_gate_a: assert property (
        q.accept |-> ($past(slave_en_i) && $past(q.dest_ok)))
        else $error("command accepted outside slave mode or foreign address");
    stop_key_a: assert property (
        keys_i.stop |=> q.pend.stop)
        else $error("stop key not queued");
    stop_halt_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_STOP) |-> (q.xport == mtcc_pkg::XP_STOP))
        else $error("stop did not halt transport");
    play_run_a: assert property (
        (q.accept && (q.acc_cmd == mtcc_pkg::CMD_PLAY || q.acc_cmd == mtcc_pkg::CMD_DPLAY)
         && $past(q.xport) != mtcc_pkg::XP_REC) |-> (q.xport == mtcc_pkg::XP_PLAY))
        else $error("play did not start playback");
    play_key_a: assert property (
        keys_i.play |=> (q.pend.dplay && !(q.start && q.start_cmd == mtcc_pkg::CMD_PLAY)))
        else $error("play key handled wrongly");
    ffwd_key_a: assert property (
        (keys_i.ffwd || keys_i.shut_fwd) |=> q.pend.ffwd)
        else $error("forward event not queued");
    ffwd_run_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_FFWD) |-> (q.xport == mtcc_pkg::XP_FFWD))
        else $error("fast forward not started");
    rewd_key_a: assert property (
        (keys_i.rewd || keys_i.shut_rev) |=> q.pend.rewd)
        else $error("rewind event not queued");
    rewd_run_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_REWD) |-> (q.xport == mtcc_pkg::XP_REWD))
        else $error("rewind not started");
    rec_begin_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_RSTROBE && $past(q.xport) == mtcc_pkg::XP_STOP)
        |-> (q.xport == mtcc_pkg::XP_REC && q.rec_start && !q.punch_in))
        else $error("record strobe from stop did not record");
    punch_in_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_RSTROBE && $past(q.xport) == mtcc_pkg::XP_PLAY)
        |-> (q.xport == mtcc_pkg::XP_REC && q.punch_in && !q.rec_start))
        else $error("record strobe from play did not punch in");
    punch_out_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_REXIT)
        |-> (q.punch_out == ($past(q.xport) == mtcc_pkg::XP_REC)))
        else $error("record exit handled wrongly");
    reset_key_a: assert property (
        keys_i.song_done |=> q.pend.reset)
        else $error("song load end not queued");
    reset_apply_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_RESET)
        |-> (q.xport == mtcc_pkg::XP_STOP && q.mmc_reset))
        else $error("reset not applied");
    discard_a: assert property (
        (rx_i.valid && rx_i.data == mtcc_pkg::EOX && q.rx_st != mtcc_pkg::RX_EOX)
        |=> (!q.accept && $stable(q.xport)))
        else $error("malformed message had an effect");
    one_start_a: assert property (
        q.start |-> !ser_busy ##1 (ser_busy && !q.start))
        else $error("message started while sender busy");
    slave_off_a: assert property (
        (rx_i.valid && rx_i.data == mtcc_pkg::EOX && !slave_en_i) |=> !q.accept)
        else $error("command accepted while not a slave");
    stop_first_a: assert property (
        (q.pend.stop && !ser_busy && !q.start)
        |=> (q.start && q.start_cmd == mtcc_pkg::CMD_STOP))
        else $error("queued stop not sent first");
    no_play_a: assert property (
        q.start |-> (q.start_cmd != mtcc_pkg::CMD_PLAY))
        else $error("plain play was sent");
    rec_only_a: assert property (
        (q.rec_start || q.punch_in) |-> (q.xport == mtcc_pkg::XP_REC))
        else $error("record pulse without recording");
    exit_idle_a: assert property (
        (q.accept && q.acc_cmd == mtcc_pkg::CMD_REXIT && $past(q.xport) != mtcc_pkg::XP_REC)
        |-> ($stable(q.xport) && !q.punch_out))
        else $error("record exit acted outside recording");
    reset_send_a: assert property (
        (q.pend.reset && !q.pend.stop && !ser_busy && !q.start)
        |=> (q.start && q.start_cmd == mtcc_pkg::CMD_RESET))
        else $error("queued reset not sent");
    rt_skip_a: assert property (
        (rx_i.valid && rx_i.data >= mtcc_pkg::RT_FIRST) |=> ($stable(q.rx_st) && !q.accept))
        else $error("real-time byte disturbed the receiver");
    status_abort_a: assert property (
        (rx_i.valid && rx_i.data[7] && rx_i.data < mtcc_pkg::RT_FIRST
         && rx_i.data != mtcc_pkg::SYSEX_START) |=> (q.rx_st == mtcc_pkg::RX_IDLE))
        else $error("status byte did not end the message");
    one_accept_a: assert property (
        q.accept |=> !q.accept)
        else $error("one message accepted twice");

endmodule : mtcc_top

// ---- src/mtcc_pkg.sv ----
// Constants, types and state records shared by the transport command codec
package mtcc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Message bytes
    localparam logic [7:0] SYSEX_START = 8'hF0;
    localparam logic [7:0] UNIV_RT     = 8'h7F;
    localparam logic [6:0] ALL_CALL    = 7'h7F;
    localparam logic [7:0] SUB_ID      = 8'h06;
    localparam logic [7:0] EOX         = 8'hF7;
    localparam logic [7:0] RT_FIRST    = 8'hF8;
    localparam logic [7:0] IDLE_BYTE   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_STOP    = 8'h01;
    localparam logic [7:0] CMD_PLAY    = 8'h02;
    localparam logic [7:0] CMD_DPLAY   = 8'h03;
    localparam logic [7:0] CMD_FFWD    = 8'h04;
    localparam logic [7:0] CMD_REWD    = 8'h05;
    localparam logic [7:0] CMD_RSTROBE = 8'h06;
    localparam logic [7:0] CMD_REXIT   = 8'h07;
    localparam logic [7:0] CMD_RESET   = 8'h0D;

    ////////////////////////////////////////////////////////////////////////////
    // Byte positions of an outgoing message
    localparam logic [2:0] IDX_FIRST   = 3'h0;
    localparam logic [2:0] IDX_UNIV    = 3'h1;
    localparam logic [2:0] IDX_DEST    = 3'h2;
    localparam logic [2:0] IDX_SUB     = 3'h3;
    localparam logic [2:0] IDX_CMD     = 3'h4;
    localparam logic [2:0] IDX_LAST    = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // Enumerations
    typedef enum logic [2:0] {
        RX_IDLE, RX_UNIV, RX_DEST, RX_SUBID, RX_CMD, RX_EOX, RX_SKIP
    } mtcc_rx_st_t;

    typedef enum logic [2:0] {
        XP_STOP, XP_PLAY, XP_FFWD, XP_REWD, XP_REC
    } mtcc_xport_t;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } mtcc_byte_t;

    typedef struct packed {
        logic stop;
        logic play;
        logic ffwd;
        logic rewd;
        logic shut_fwd;
        logic shut_rev;
        logic song_done;
    } mtcc_keys_t;

    typedef struct packed {
        logic stop;
        logic reset;
        logic dplay;
        logic ffwd;
        logic rewd;
    } mtcc_pend_t;

    ////////////////////////////////////////////////////////////////////////////
    // State records
    typedef struct packed {
        logic       busy;
        logic [2:0] idx;
        logic [7:0] cmd;
        mtcc_byte_t out;
    } mtcc_ser_st_t;

    typedef struct packed {
        mtcc_rx_st_t rx_st;
        logic        dest_ok;
        logic [7:0]  cmd;
        mtcc_xport_t xport;
        mtcc_pend_t  pend;
        logic        start;
        logic [7:0]  start_cmd;
        logic        accept;
        logic [7:0]  acc_cmd;
        logic        rec_start;
        logic        punch_in;
        logic        punch_out;
        logic        mmc_reset;
    } mtcc_top_st_t;

endpackage : mtcc_pkg

// ---- src/mtcc_tx_ser.sv ----
// Outgoing message serialiser: one six-byte machine-control message per start
`timescale 1ns/100ps
module mtcc_tx_ser (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               resetn_i,
    // Request
    input  wire logic               start_i,
    input  wire logic [7:0]         cmd_i,
    output logic                    busy_o,
    // Byte stream
    output mtcc_pkg::mtcc_byte_t    tx_o,
    input  wire logic               tx_ready_i
);

    mtcc_pkg::mtcc_ser_st_t q;
    mtcc_pkg::mtcc_ser_st_t d;

    ////////////////////////////////////////////////////////////////////////////
    // Byte at a position of the message
    function automatic logic [7:0] byte_at(input logic [2:0] idx, input logic [7:0] cmd);
        logic [7:0] b;
        b = mtcc_pkg::IDLE_BYTE;
        unique case (idx)
            mtcc_pkg::IDX_FIRST: b = mtcc_pkg::SYSEX_START;
            mtcc_pkg::IDX_UNIV:  b = mtcc_pkg::UNIV_RT;
            mtcc_pkg::IDX_DEST:  b = {1'b0, mtcc_pkg::ALL_CALL};
            mtcc_pkg::IDX_SUB:   b = mtcc_pkg::SUB_ID;
            mtcc_pkg::IDX_CMD:   b = cmd;
            mtcc_pkg::IDX_LAST:  b = mtcc_pkg::EOX;
            default:             b = mtcc_pkg::IDLE_BYTE;
        endcase
        return b;
    endfunction : byte_at

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        d = q;
        if (!q.busy && start_i)
        begin
            d.busy      = 1'b1;
            d.idx       = mtcc_pkg::IDX_FIRST;
            d.cmd       = cmd_i;
            d.out.valid = 1'b1;
            d.out.data  = mtcc_pkg::SYSEX_START;
        end
        else if (q.busy && tx_ready_i)
        begin
            if (q.idx == mtcc_pkg::IDX_LAST)
            begin
                d.busy      = 1'b0;
                d.out.valid = 1'b0;
                d.out.data  = mtcc_pkg::IDLE_BYTE;
            end
            else
            begin
                d.idx      = q.idx + 3'h1;
                d.out.data = byte_at(d.idx, q.cmd);
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            q <= '0;
        else
            q <= d;
    end

    assign busy_o = q.busy;
    assign tx_o   = q.out;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    hdr_order_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (q.out.valid && tx_ready_i && q.out.data == mtcc_pkg::SYSEX_START)
        |=> (q.out.valid && q.out.data == mtcc_pkg::UNIV_RT))
        else $error("start byte not followed by universal id");
    dest_all_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (q.out.valid && q.idx == mtcc_pkg::IDX_UNIV && tx_ready_i)
        |=> (q.out.data[6:0] == mtcc_pkg::ALL_CALL))
        else $error("outgoing destination is not all-call");
    tail_order_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (q.out.valid && tx_ready_i && q.idx == mtcc_pkg::IDX_CMD)
        |=> (q.out.valid && q.out.data == mtcc_pkg::EOX))
        else $error("command byte not followed by end byte");
    no_mix_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (q.out.valid && !tx_ready_i) |=> (q.out.valid && $stable(q.out.data)))
        else $error("outgoing byte changed while stalled");

endmodule : mtcc_tx_ser

// ---- sim/mtcc_peer.sv ----
// Far-side byte sink: takes sent bytes with random stalls and reports each
`timescale 1ns/100ps
module mtcc_peer (
    // Clock and reset
    input  wire logic            clock_i,
    input  wire logic            resetn_i,
    // Byte stream
    input  mtcc_pkg::mtcc_byte_t tx_i,
    output logic                 ready_o,
    // Report
    output logic                 got_o,
    output logic [7:0]           got_byte_o
);
    integer seed = 32'h304D;
    always @(posedge clock_i or negedge resetn_i)
        if (!resetn_i)
        begin
            ready_o <= 1'b0;
            got_o   <= 1'b0;
        end
        else
        begin
            got_o      <= tx_i.valid && ready_o;
            got_byte_o <= tx_i.data;
            ready_o    <= ($random(seed) & 3) != 0;
        end
endmodule : mtcc_peer

// ---- sim/tb_top.sv ----
// Testbench: random and corner traffic through the transport command codec
`timescale 1ns/100ps
module tb_top;
    logic                  clock_i = 1'b0;
    logic                  resetn_i = 1'b0;
    logic                  slave_en_i = 1'b0;
    logic [6:0]            own_id_i = 7'h00;
    mtcc_pkg::mtcc_keys_t  keys_i = '0;
    mtcc_pkg::mtcc_byte_t  rx_i = '0;
    mtcc_pkg::mtcc_byte_t  tx_o;
    mtcc_pkg::mtcc_xport_t xport_o;
    logic [2:0]            xp;
    logic                  tx_ready_i, got, rec_start_o, punch_in_o, punch_out_o;
    logic                  mmc_reset_o, cmd_accept_o;
    logic [7:0]            gb, cmd_code_o, lc, c;
    logic [6:0]            k;
    logic [4:0]            pl;
    logic [7:0]            q[$], e[$];
    logic [7:0]            cmds[10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                        8'h0D, 8'h0F, 8'h44};
    integer                seed = 32'h304D;
    integer                n_fail = 0;
    integer                total_checks = 0;
    int                    bad, r, ix;
    wire  [4:0]            pulses = {rec_start_o, punch_in_o, punch_out_o, mmc_reset_o,
                                     cmd_accept_o};
    always #12.5 clock_i = ~clock_i;
    mtcc_top i_dut (.clock_i, .resetn_i, .slave_en_i, .own_id_i, .keys_i, .rx_i, .tx_o,
        .tx_ready_i, .xport_o, .rec_start_o, .punch_in_o, .punch_out_o, .mmc_reset_o,
        .cmd_accept_o, .cmd_code_o);
    mtcc_peer i_peer (.clock_i, .resetn_i, .tx_i(tx_o), .ready_o(tx_ready_i), .got_o(got),
        .got_byte_o(gb));
    always @(posedge clock_i) if (got) q.push_back(gb);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
        total_checks++;
        if (g !== x)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    // Transport and pulses {rec_start, punch_in, punch_out, reset, accept} after a command
    function automatic logic [7:0] exp_step(input logic [7:0] cmd, input logic [2:0] x);
        logic [4:0] p;
        p = 5'h01;
        case (cmd)
            8'h01: x = mtcc_pkg::XP_STOP;
            8'h02, 8'h03: if (x != mtcc_pkg::XP_REC) x = mtcc_pkg::XP_PLAY;
            8'h04: x = mtcc_pkg::XP_FFWD;
            8'h05: x = mtcc_pkg::XP_REWD;
            8'h06: if (x == mtcc_pkg::XP_STOP) {x, p[4]} = {mtcc_pkg::XP_REC, 1'b1};
                else if (x == mtcc_pkg::XP_PLAY) {x, p[3]} = {mtcc_pkg::XP_REC, 1'b1};
            8'h07: if (x == mtcc_pkg::XP_REC) {x, p[2]} = {mtcc_pkg::XP_PLAY, 1'b1};
            default: {x, p[1]} = {mtcc_pkg::XP_STOP, 1'b1};
        endcase
        return {x, p};
    endfunction : exp_step
    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic put(input logic [7:0] b);
        @(posedge clock_i);
        rx_i <= '{valid: 1'b1, data: b};
    endtask : put
    // Six-byte message, optionally spoilt, with a clock byte slipped in at random
    task automatic rx_msg(input logic [6:0] d);
        logic [7:0] m[6];
        m = '{8'hF0, bad == 1 ? 8'h7E : 8'h7F, {1'b0, d}, bad == 2 ? 8'h05 : 8'h06, c, 8'hF7};
        for (int i = 0; i < 6; i++)
        begin
            put(m[i]);
            if (bad >= 3 && i == 4) put(bad == 3 ? 8'h11 : 8'hF1);
            if (i == 2 && seed[1]) put(8'hF8);
        end
        @(posedge clock_i);
        rx_i <= '{valid: 1'b0, data: ~rx_i.data};
        #1;
    endtask : rx_msg
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25 * 20000);
        n_fail++;
        stop_test();
    end
    initial
    begin
        xp = mtcc_pkg::XP_STOP;
        lc = 8'h00;
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        for (int n = 0; n < 300; n++)
        begin
            own_id_i   <= 7'($random(seed) & 7'h3F);
            slave_en_i <= ($random(seed) & 3) != 0;
            r = $random(seed) & 3;
            ix = ($random(seed) & 15) % 10;
            c = cmds[ix];
            bad = $random(seed) & 7;
            if (bad > 4) bad = 0;
            #1;
            rx_msg(r == 1 ? 7'h7F : (r == 2 ? own_id_i + 7'h01 : own_id_i));
            pl = 5'h00;
            if (slave_en_i && r != 2 && bad == 0 && ix < 8)
            begin
                lc = c;
                {xp, pl} = exp_step(c, xp);
            end
            chk("xport", 8'(xp), 8'(xport_o));
            chk("pulses", 8'(pl), 8'(pulses));
            chk("code", lc, cmd_code_o);
        end
        // Reset in mid-run returns everything to idle
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        chk("rst xport", 8'(mtcc_pkg::XP_STOP), 8'(xport_o));
        chk("rst valid", 8'h00, 8'(tx_o.valid));
        resetn_i <= 1'b1;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge clock_i);
            k = n < 7 ? 7'h40 >> n : 7'($random(seed));
            keys_i <= k;
            @(posedge clock_i);
            keys_i <= '0;
            if (k[6]) e.push_back(8'h01);
            if (k[0]) e.push_back(8'h0D);
            if (k[5]) e.push_back(8'h03);
            if (k[4] | k[2]) e.push_back(8'h04);
            if (k[3] | k[1]) e.push_back(8'h05);
            for (int t = 0; t < 600 && q.size() < 6 * e.size(); t++) @(posedge clock_i);
            repeat (4) @(posedge clock_i);
            #1;
            chk("count", 8'(6 * e.size()), 8'(q.size()));
            while (e.size() > 0 && q.size() >= 6)
            begin
                chk("tx start", mtcc_pkg::SYSEX_START, q.pop_front());
                chk("tx univ", mtcc_pkg::UNIV_RT, q.pop_front());
                chk("tx dest", {1'b0, mtcc_pkg::ALL_CALL}, q.pop_front());
                chk("tx sub", mtcc_pkg::SUB_ID, q.pop_front());
                chk("tx cmd", e.pop_front(), q.pop_front());
                chk("tx end", mtcc_pkg::EOX, q.pop_front());
            end
            e.delete();
            q.delete();
        end
        stop_test();
    end
endmodule : tb_top
